/* logic/bst_defines.svh */
// Constants of the boundary-scan test access port.
// Assumes inclusion by bare name from the package and the port module.
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

`define BST_IR_W 8
`define BST_IR_BYPASS 8'hFF
`define BST_IR_EXTEST 8'h00
`define BST_IR_INTEST 8'h40
`define BST_IR_SAMPLE_MASK 8'h3F
`define BST_IR_SAMPLE 8'h0B
`define BST_IR_CAPTURE 8'h01
`define BST_KIND_IN 2'h0
`define BST_KIND_OUT 2'h1
`define BST_KIND_TRI 2'h2
`define BST_CHAIN_LEN 94
`define BST_FS_OE_CELL 26
`define BST_TCK_MAX_MHZ 5

`endif

/* logic/bst_pkg.sv */
// Types shared by the boundary-scan test access port.
// Assumes the constants header sits beside it.
`include "bst_defines.svh"

package bst_pkg;

	typedef enum logic [15:0] {
		BST_TLR = 16'h0001,
		BST_RTI = 16'h0002,
		BST_SEL_DR = 16'h0004,
		BST_CAP_DR = 16'h0008,
		BST_SHIFT_DR = 16'h0010,
		BST_EXIT1_DR = 16'h0020,
		BST_PAUSE_DR = 16'h0040,
		BST_EXIT2_DR = 16'h0080,
		BST_UPD_DR = 16'h0100,
		BST_SEL_IR = 16'h0200,
		BST_CAP_IR = 16'h0400,
		BST_SHIFT_IR = 16'h0800,
		BST_EXIT1_IR = 16'h1000,
		BST_PAUSE_IR = 16'h2000,
		BST_EXIT2_IR = 16'h4000,
		BST_UPD_IR = 16'h8000
	} bst_state_type;

	typedef enum logic [3:0] {
		BST_SEL_BYPASS = 4'h1,
		BST_SEL_EXTEST = 4'h2,
		BST_SEL_INTEST = 4'h4,
		BST_SEL_SAMPLE = 4'h8
	} bst_instr_type;

	typedef struct packed {
		logic data;
		logic en;
	} bst_tdo_type;

endpackage

/* logic/bst_tap.sv */
// Test access port controller and boundary chain.
// Assumes tck_i is free of mclk_i; TRST is asynchronous to both.
`include "bst_defines.svh"

module bst_tap #(
	parameter int CHAIN_LEN = `BST_CHAIN_LEN,
	parameter logic [2*CHAIN_LEN-1:0] CELL_KINDS = {CHAIN_LEN{`BST_KIND_OUT}},
	parameter int FS_OE_CELL = `BST_FS_OE_CELL
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic tck_i,
	input wire logic trst_n_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	input wire logic [CHAIN_LEN-1:0] pad_in_i,
	input wire logic [CHAIN_LEN-1:0] core_out_i,
	output logic [CHAIN_LEN-1:0] pad_out_o,
	output logic [CHAIN_LEN-1:0] core_in_o,
	output logic frame_store_pins_output_enable_o,
	output logic scan_active_o
);

	bst_pkg::bst_state_type state_q, state_d;
	bst_pkg::bst_instr_type sel;
	logic [`BST_IR_W-1:0] ir_q, ir_d;
	logic [`BST_IR_W-1:0] instr_q, instr_d;
	logic bypass_q, bypass_d;
	logic [CHAIN_LEN-1:0] chain_q, chain_d;
	logic [CHAIN_LEN-1:0] upd_q, upd_d;
	logic [CHAIN_LEN-1:0] cap;
	logic [CHAIN_LEN-1:0] is_in;
	logic test_lvl_q, test_lvl_d;
	bst_pkg::bst_tdo_type tdo_q, tdo_d;
	logic sync1_q, sync2_q, act_q;
	logic sync1_d, sync2_d, act_d;

	// Controller, TMS sampled on rising TCK
	always_comb begin
		state_d = state_q;
		case (state_q)
			bst_pkg::BST_TLR: state_d = tms_i ? bst_pkg::BST_TLR : bst_pkg::BST_RTI;
			bst_pkg::BST_RTI: state_d = tms_i ? bst_pkg::BST_SEL_DR : bst_pkg::BST_RTI;
			bst_pkg::BST_SEL_DR: state_d = tms_i ? bst_pkg::BST_SEL_IR : bst_pkg::BST_CAP_DR;
			bst_pkg::BST_CAP_DR: state_d = tms_i ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
			bst_pkg::BST_SHIFT_DR: state_d = tms_i ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
			bst_pkg::BST_EXIT1_DR: state_d = tms_i ? bst_pkg::BST_UPD_DR : bst_pkg::BST_PAUSE_DR;
			bst_pkg::BST_PAUSE_DR: state_d = tms_i ? bst_pkg::BST_EXIT2_DR : bst_pkg::BST_PAUSE_DR;
			bst_pkg::BST_EXIT2_DR: state_d = tms_i ? bst_pkg::BST_UPD_DR : bst_pkg::BST_SHIFT_DR;
			bst_pkg::BST_UPD_DR: state_d = tms_i ? bst_pkg::BST_SEL_DR : bst_pkg::BST_RTI;
			bst_pkg::BST_SEL_IR: state_d = tms_i ? bst_pkg::BST_TLR : bst_pkg::BST_CAP_IR;
			bst_pkg::BST_CAP_IR: state_d = tms_i ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
			bst_pkg::BST_SHIFT_IR: state_d = tms_i ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
			bst_pkg::BST_EXIT1_IR: state_d = tms_i ? bst_pkg::BST_UPD_IR : bst_pkg::BST_PAUSE_IR;
			bst_pkg::BST_PAUSE_IR: state_d = tms_i ? bst_pkg::BST_EXIT2_IR : bst_pkg::BST_PAUSE_IR;
			bst_pkg::BST_EXIT2_IR: state_d = tms_i ? bst_pkg::BST_UPD_IR : bst_pkg::BST_SHIFT_IR;
			bst_pkg::BST_UPD_IR: state_d = tms_i ? bst_pkg::BST_SEL_DR : bst_pkg::BST_RTI;
			default: state_d = bst_pkg::BST_TLR;
		endcase
	end

	// Decode; anything unlisted falls back to bypass
	always_comb begin
		if (instr_q == `BST_IR_BYPASS) begin
			sel = bst_pkg::BST_SEL_BYPASS;
		end else if (instr_q == `BST_IR_EXTEST) begin
			sel = bst_pkg::BST_SEL_EXTEST;
		end else if (instr_q == `BST_IR_INTEST) begin
			sel = bst_pkg::BST_SEL_INTEST;
		end else if ((instr_q & `BST_IR_SAMPLE_MASK) == `BST_IR_SAMPLE) begin
			sel = bst_pkg::BST_SEL_SAMPLE;
		end else begin
			sel = bst_pkg::BST_SEL_BYPASS;
		end
	end

	// Eight-bit instruction path, no parity stage
	always_comb begin
		ir_d = ir_q;
		instr_d = instr_q;
		if (state_q == bst_pkg::BST_TLR) begin
			instr_d = `BST_IR_BYPASS;
		end
		if (state_q == bst_pkg::BST_CAP_IR) begin
			ir_d = `BST_IR_CAPTURE;
		end else if (state_q == bst_pkg::BST_SHIFT_IR) begin
			ir_d = {tdi_i, ir_q[`BST_IR_W-1:1]};
		end else if (state_q == bst_pkg::BST_UPD_IR) begin
			instr_d = ir_q;
		end
	end

	// Cell kinds; the frame-store enable cell is forced three-state
	genvar gi;
	generate
		for (gi = 0; gi < CHAIN_LEN; gi++) begin : g_cell
			localparam logic [1:0] KIND = (gi == FS_OE_CELL) ? `BST_KIND_TRI : CELL_KINDS[2*gi +: 2];
			assign is_in[gi] = (KIND == `BST_KIND_IN);
			// Inputs capture the pad, outputs and enables the core side
			assign cap[gi] = is_in[gi] ? pad_in_i[gi] : core_out_i[gi];
			assign pad_out_o[gi] = (!is_in[gi] && sel == bst_pkg::BST_SEL_EXTEST) ?
				upd_q[gi] : core_out_i[gi];
			assign core_in_o[gi] = (is_in[gi] && sel == bst_pkg::BST_SEL_INTEST) ?
				upd_q[gi] : pad_in_i[gi];
		end
	endgenerate

	// One enable cell gates every frame-store pin
	assign frame_store_pins_output_enable_o = pad_out_o[FS_OE_CELL];

	// Data registers; TDI enters the highest position, index 0 faces TDO
	always_comb begin
		bypass_d = bypass_q;
		chain_d = chain_q;
		upd_d = upd_q;
		if (state_q == bst_pkg::BST_CAP_DR) begin
			bypass_d = 1'b0;
			if (sel != bst_pkg::BST_SEL_BYPASS) begin
				chain_d = cap;
			end
		end else if (state_q == bst_pkg::BST_SHIFT_DR) begin
			if (sel == bst_pkg::BST_SEL_BYPASS) begin
				bypass_d = tdi_i;
			end else begin
				chain_d = {tdi_i, chain_q[CHAIN_LEN-1:1]};
			end
		end else if (state_q == bst_pkg::BST_UPD_DR && sel != bst_pkg::BST_SEL_BYPASS) begin
			upd_d = chain_q;
		end
	end

	// Pins leave core control only under EXTEST or INTEST
	always_comb begin
		test_lvl_d = (sel == bst_pkg::BST_SEL_EXTEST) || (sel == bst_pkg::BST_SEL_INTEST);
	end

	// All test registers on TCK, reset by TRST alone; IR loads the capture code, the instruction bypass
	always_ff @(posedge tck_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			state_q <= bst_pkg::BST_TLR;
			ir_q <= `BST_IR_CAPTURE;
			instr_q <= `BST_IR_BYPASS;
			bypass_q <= 1'b0;
			chain_q <= '0;
			upd_q <= '0;
			test_lvl_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ir_q <= ir_d;
			instr_q <= instr_d;
			bypass_q <= bypass_d;
			chain_q <= chain_d;
			upd_q <= upd_d;
			test_lvl_q <= test_lvl_d;
		end
	end

	// TDO source picked ahead of the falling edge
	always_comb begin
		tdo_d.data = tdo_q.data;
		tdo_d.en = 1'b0;
		if (state_q == bst_pkg::BST_SHIFT_IR) begin
			tdo_d.data = ir_q[0];
			tdo_d.en = 1'b1;
		end else if (state_q == bst_pkg::BST_SHIFT_DR) begin
			tdo_d.data = (sel == bst_pkg::BST_SEL_BYPASS) ? bypass_q : chain_q[0];
			tdo_d.en = 1'b1;
		end
	end

	// Falling edge gives the tester half a period of hold
	always_ff @(negedge tck_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			tdo_q <= '0;
		end else begin
			tdo_q <= tdo_d;
		end
	end

	assign tdo_o = tdo_q.data;
	assign tdo_oe_o = tdo_q.en;

	// Test-mode level crossed into the system clock
	always_comb begin
		sync1_d = test_lvl_q;
		sync2_d = sync1_q;
		act_d = sync2_q;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			act_q <= 1'b0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			act_q <= act_d;
		end
	end

	assign scan_active_o = act_q;

	// Checks on the TCK domain
	sequence s_tms_five;
		tms_i [*5];
	endsequence

	sequence s_ir_load;
		state_q == bst_pkg::BST_UPD_IR;
	endsequence

	property p_reset_walk;
		@(posedge tck_i) disable iff (!trst_n_i)
		s_tms_five |=> state_q == bst_pkg::BST_TLR;
	endproperty

	property p_ir_update;
		@(posedge tck_i) disable iff (!trst_n_i)
		s_ir_load |=> instr_q == $past(ir_q);
	endproperty

	a_tms_reset_walk: assert property (p_reset_walk)
		else $error("five TMS highs did not reach reset state");

	a_ir_update_load: assert property (p_ir_update)
		else $error("instruction not loaded on update");

	a_bypass_ones_decode: assert property (@(posedge tck_i) disable iff (!trst_n_i)
		instr_q == `BST_IR_BYPASS |-> sel == bst_pkg::BST_SEL_BYPASS)
		else $error("all ones did not select bypass");

	a_extest_zero_decode: assert property (@(posedge tck_i) disable iff (!trst_n_i)
		instr_q == `BST_IR_EXTEST |-> sel == bst_pkg::BST_SEL_EXTEST && (pad_out_o & ~is_in) == (upd_q & ~is_in))
		else $error("extest not driving update cells");

	a_intest_code_decode: assert property (@(posedge tck_i) disable iff (!trst_n_i)
		instr_q == `BST_IR_INTEST |-> sel == bst_pkg::BST_SEL_INTEST)
		else $error("intest code not decoded");

	a_sample_low_bits: assert property (@(posedge tck_i) disable iff (!trst_n_i)
		(instr_q & `BST_IR_SAMPLE_MASK) == `BST_IR_SAMPLE |-> sel == bst_pkg::BST_SEL_SAMPLE)
		else $error("sample code not decoded");

	a_unlisted_core_pins: assert property (@(posedge tck_i) disable iff (!trst_n_i)
		sel == bst_pkg::BST_SEL_BYPASS |-> pad_out_o == core_out_i && core_in_o == pad_in_i)
		else $error("bypass took pins from the core");

	a_bypass_captures_zero: assert property (@(posedge tck_i) disable iff (!trst_n_i)
		state_q == bst_pkg::BST_CAP_DR ##1 state_q == bst_pkg::BST_SHIFT_DR |-> !bypass_q)
		else $error("bypass did not capture zero");

endmodule // bst_tap

/* verification/bst_tester.sv */
// Tester model: drives the test pins and reads TDO.
// Assumes the bench calls its tasks one at a time, starting from idle.
module bst_tester (
	output logic tck_o,
	output logic trst_n_o,
	output logic tms_o,
	output logic tdi_o,
	input wire logic tdo_i
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 100; // Keeps TCK at 5 MHz
	event done_e;
	logic [95:0] res;
	initial begin
		tck_o = 1'b0;
		trst_n_o = 1'b1;
		tms_o = 1'b1;
		tdi_o = 1'b0;
		res = '0;
	end
	// Clock stands low between frames
	task automatic step(input logic m, input logic d, output logic q);
		tms_o = m;
		tdi_o = d;
		#HALF;
		tck_o = 1'b1;
		q = tdo_i;
		#HALF;
		tck_o = 1'b0;
	endtask
	task automatic to_idle();
		logic q;
		step(1'b0, tdi_o, q);
	endtask
	task automatic pulse_reset();
		trst_n_o = 1'b0;
		#(2 * HALF);
		trst_n_o = 1'b1;
		to_idle();
	endtask
	task automatic to_reset();
		logic q;
		for (int i = 0; i < 5; i++) begin
			step(1'b1, 1'b0, q);
		end
		to_idle();
	endtask
	task automatic scan(input logic ir, input int n, input logic [95:0] din);
		logic q;
		step(1'b1, 1'b0, q);
		if (ir) begin
			step(1'b1, 1'b0, q);
		end
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(logic'(i == n - 1), din[i], q); // Index 0 first
			res[i] = q;
		end
		// Line no longer shifted shows the inverse, not a stale bit
		step(1'b1, ~din[n-1], q);
		to_idle();
		-> done_e;
	endtask
endmodule // bst_tester

/* verification/tb_boundary_scan_tap.sv */
// Self-checking bench for the test access port and a short chain.
// Assumes the tester model beside it and the design under logic/.
module tb_boundary_scan_tap;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int N = 8;
	localparam logic [7:0] IN_MASK = 8'h49;
	logic mclk, reset, tck, trst_n, tms, tdi, tdo, tdo_oe, fs_oe, scan_act;
	logic [N-1:0] pad_in, core_out, pad_out, core_in;
	logic [95:0] exp_q[$];
	logic [7:0] p;
	int mismatches, check_count, oe_hi;
	bst_tap #(.CHAIN_LEN(N), .CELL_KINDS(16'h4524), .FS_OE_CELL(2)) DUT (.mclk_i(mclk), .reset_i(reset),
		.tck_i(tck), .trst_n_i(trst_n), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
		.pad_in_i(pad_in), .core_out_i(core_out), .pad_out_o(pad_out), .core_in_o(core_in),
		.frame_store_pins_output_enable_o(fs_oe), .scan_active_o(scan_act));
	bst_tester tst (.tck_o(tck), .trst_n_o(trst_n), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic check(input logic [95:0] got, input logic [95:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	function automatic logic [7:0] cap();
		return (pad_in & IN_MASK) | (core_out & ~IN_MASK);
	endfunction
	task automatic ir(input logic [7:0] c);
		exp_q.push_back(96'h01);
		tst.scan(1'b1, 8, {88'h0, c});
	endtask
	task automatic dr(input logic [7:0] d, input logic [7:0] e);
		exp_q.push_back({88'h0, e});
		tst.scan(1'b0, N, {88'h0, d});
	endtask
	task automatic drive();
		@(posedge mclk);
		#5;
		pad_in = N'($urandom);
		core_out = N'($urandom);
		// Let the pin muxes settle before anyone compares
		#1;
	endtask
	initial forever begin
		@(tst.done_e);
		check(tst.res, exp_q.pop_front());
	end
	always @(tdo) if (tck === 1'b1) check(1'b1, 1'b0);
	always @(posedge tck) if (tdo_oe === 1'b1) oe_hi++;
	initial begin
		#1000000;
		mismatches++;
		finish_test();
	end
	initial begin
		void'($urandom(32'hDA67));
		reset = 1'b1;
		pad_in = '0;
		core_out = '0;
		repeat (4) @(posedge mclk);
		#5 reset = 1'b0;
		tst.pulse_reset();
		drive();
		check(pad_out, core_out);
		ir(8'h55);
		check(oe_hi, 8);
		check(tdo_oe, 1'b0);
		dr(8'hA6, 8'h4C);
		check(pad_out, core_out);
		check(core_in, pad_in);
		for (int k = 0; k < 4; k++) begin
			drive();
			ir({k[1:0], 6'h0B});
			p = 8'($urandom);
			dr(p, cap());
			check(pad_out, core_out);
		end
		ir(8'h00);
		drive();
		p = 8'($urandom);
		dr(p, cap());
		check(pad_out, (p & ~IN_MASK) | (core_out & IN_MASK));
		check(fs_oe, p[2]);
		repeat (4) @(posedge mclk);
		#5;
		check(scan_act, 1'b1);
		ir(8'h40);
		p = 8'($urandom);
		dr(p, cap());
		check(core_in, (p & IN_MASK) | (pad_in & ~IN_MASK));
		tst.to_reset();
		check(core_in, pad_in);
		ir(8'h00);
		// One idle edge so the test level is set before TRST clears it
		tst.to_idle();
		repeat (4) @(posedge mclk);
		#5;
		check(scan_act, 1'b1);
		tst.pulse_reset();
		check(pad_out, core_out);
		repeat (4) @(posedge mclk);
		#5;
		check(scan_act, 1'b0);
		#1;
		finish_test();
	end
endmodule // tb_boundary_scan_tap
